/* File: verilog/indexed_operand_substitution.sv */
// indexed_operand_substitution: executes indexed statement pairs
// assumes a statement fetch that honours stmt_ready and a word memory
// that answers a read with mem_rd_valid some cycles later
`timescale 1ns/1ps
module indexed_operand_substitution
	import indexed_pkg::*;
(
	input  wire logic                            clk,
	input  wire logic                            srst,
	input  wire logic                            stmt_valid,
	input  wire indexed_pkg::op_t                stmt_op,
	input  wire indexed_pkg::opnd_t              stmt_opnd,
	input  wire logic [indexed_pkg::PARAM_W-1:0] stmt_param,
	output logic                                 stmt_ready,
	output logic                                 mem_rd_req,
	output indexed_pkg::area_t                   mem_rd_area,
	output logic [indexed_pkg::INDEX_W-1:0]      mem_rd_addr,
	input  wire logic                            mem_rd_valid,
	input  wire logic [indexed_pkg::PARAM_W-1:0] mem_rd_data,
	output logic                                 exec_valid,
	output indexed_pkg::op_t                     exec_op,
	output indexed_pkg::opnd_t                   exec_opnd,
	output logic [indexed_pkg::PARAM_W-1:0]      exec_param,
	output logic                                 exec_indexed,
	output logic                                 pair_busy,
	output logic                                 index_error
);
	import indexed_pkg::*;

	// ************************************************************
	// sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH_WORD,
		ST_WAIT_NEXT
	} state_t;

	state_t                 state_reg;
	state_t                 state_next;
	logic [PARAM_W-1:0]     index_word_reg;
	logic                   stmt_ready_reg;
	logic                   mem_rd_req_reg;
	area_t                  mem_rd_area_reg;
	logic [INDEX_W-1:0]     mem_rd_addr_reg;
	logic                   exec_valid_reg;
	op_t                    exec_op_reg;
	opnd_t                  exec_opnd_reg;
	logic [PARAM_W-1:0]     exec_param_reg;
	logic                   exec_indexed_reg;
	logic                   pair_busy_reg;
	logic                   index_error_reg;
	wire                    permitted;
	wire                    bit_operand;

	indexed_permit u_permit (
		.op          (stmt_op),
		.opnd        (stmt_opnd),
		.permitted   (permitted),
		.bit_operand (bit_operand)
	);

	// ************************************************************
	// decode
	// ************************************************************
	wire accept      = stmt_valid && stmt_ready_reg;
	wire is_do       = (stmt_op == OP_DO);
	wire do_opnd_ok  = (stmt_opnd == OPND_FLAG_WORD) || (stmt_opnd == OPND_DATA_WORD);
	// logic result bit is deliberately not an input here
	wire do_start    = accept && (state_reg == ST_IDLE) && is_do;
	wire do_legal    = do_opnd_ok && (stmt_param[7:0] <= INDEX_MAX) &&
		(stmt_param[15:8] == HIGH_CLEAR);
	wire do_area_dat = (stmt_opnd == OPND_DATA_WORD);
	wire plain_exec  = accept && (state_reg == ST_IDLE) && !is_do;
	wire pair_take   = accept && (state_reg == ST_WAIT_NEXT);
	wire pair_ok     = pair_take && permitted;
	wire pair_bad    = pair_take && !permitted;
	wire word_in     = (state_reg == ST_FETCH_WORD) && mem_rd_valid;
	wire rd_launch   = do_start && do_legal;
	wire exec_fire   = plain_exec || pair_ok;
	// a second indexed instruction as partner also lands here
	wire error_fire  = pair_bad || (do_start && !do_legal);

	// ************************************************************
	// operand substitution
	// ************************************************************
	// bit ops: high byte is bit address, low byte is byte address, kept in place
	// non-bit ops: only the low byte is a parameter; a stray high byte is dropped
	wire [PARAM_W-1:0] subst_param = bit_operand ? index_word_reg :
		{HIGH_CLEAR, index_word_reg[7:0]};
	// coded parameter of the partner is ignored
	wire [PARAM_W-1:0] param_sel = pair_ok ? subst_param : stmt_param;

	// ************************************************************
	// next output values
	// ************************************************************
	// ready drops for the whole word read, so nothing slips into the pair
	wire stmt_ready_next = (state_next != ST_FETCH_WORD) && !rd_launch;
	wire pair_busy_next  = (state_next != ST_IDLE);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (rd_launch) begin
					state_next = ST_FETCH_WORD;
				end
			end
			ST_FETCH_WORD: begin
				if (mem_rd_valid) begin
					state_next = ST_WAIT_NEXT;
				end
			end
			ST_WAIT_NEXT: begin
				// back to own parameters after exactly one statement
				if (pair_take) begin
					state_next = ST_IDLE;
				end
			end
			// the fourth code is unreachable; fall back to idle if it ever appears
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// word is read fresh on every legal indexed instruction, never cached
	always_ff @(posedge clk) begin
		if (srst) begin
			index_word_reg <= '0;
		end else if (word_in) begin
			index_word_reg <= mem_rd_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mem_rd_req_reg  <= 1'b0;
			mem_rd_area_reg <= AREA_FLAG;
			mem_rd_addr_reg <= '0;
		end else begin
			mem_rd_req_reg <= rd_launch;
			if (do_start) begin
				mem_rd_area_reg <= do_area_dat ? AREA_DATA : AREA_FLAG;
				mem_rd_addr_reg <= stmt_param[7:0];
			end
		end
	end

	// fetch stalls while the word is read, so the partner follows directly
	always_ff @(posedge clk) begin
		if (srst) begin
			stmt_ready_reg <= 1'b0;
			pair_busy_reg  <= 1'b0;
		end else begin
			stmt_ready_reg <= stmt_ready_next;
			pair_busy_reg  <= pair_busy_next;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			exec_valid_reg   <= 1'b0;
			exec_indexed_reg <= 1'b0;
			index_error_reg  <= 1'b0;
		end else begin
			exec_valid_reg   <= exec_fire;
			exec_indexed_reg <= pair_ok;
			index_error_reg  <= error_fire;
		end
	end

	// data fields hold the last executed statement between pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			exec_op_reg    <= OP_OTHER;
			exec_opnd_reg  <= OPND_NONE;
			exec_param_reg <= '0;
		end else if (exec_fire) begin
			exec_op_reg    <= stmt_op;
			exec_opnd_reg  <= stmt_opnd;
			exec_param_reg <= param_sel;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign stmt_ready   = stmt_ready_reg;
	assign mem_rd_req   = mem_rd_req_reg;
	assign mem_rd_area  = mem_rd_area_reg;
	assign mem_rd_addr  = mem_rd_addr_reg;
	assign exec_valid   = exec_valid_reg;
	assign exec_op      = exec_op_reg;
	assign exec_opnd    = exec_opnd_reg;
	assign exec_param   = exec_param_reg;
	assign exec_indexed = exec_indexed_reg;
	assign pair_busy    = pair_busy_reg;
	assign index_error  = index_error_reg;

endmodule

/* File: verilog/indexed_pkg.sv */
// indexed_pkg: shared types and constants for indexed operand substitution
// assumes statements arrive already split into operation, operand and parameter
package indexed_pkg;

	// ************************************************************
	// widths and limits
	// ************************************************************
	localparam int          PARAM_W    = 16;
	localparam int          INDEX_W    = 8;
	localparam logic [7:0]  INDEX_MAX  = 8'hfe;
	localparam logic [7:0]  HIGH_CLEAR = 8'h00;

	// ************************************************************
	// operations and operand identifiers
	// ************************************************************
	typedef enum logic [4:0] {
		OP_LOAD,
		OP_TRANSFER,
		OP_SELECT_DB,
		OP_JUMP_U,
		OP_JUMP_C,
		OP_AND,
		OP_AND_NOT,
		OP_ASSIGN,
		OP_SET,
		OP_RESET,
		OP_TIMER_SS,
		OP_TIMER_SE,
		OP_SHIFT_L,
		OP_SHIFT_R,
		OP_OR,
		OP_INCREMENT,
		OP_DECREMENT,
		OP_DO,
		OP_OTHER
	} op_t;

	typedef enum logic [4:0] {
		OPND_NONE,
		OPND_FLAG_BYTE,
		OPND_FLAG_WORD,
		OPND_INPUT_BYTE,
		OPND_OUTPUT_BYTE,
		OPND_INPUT_WORD,
		OPND_OUTPUT_WORD,
		OPND_DATA_LEFT,
		OPND_DATA_RIGHT,
		OPND_DATA_WORD,
		OPND_FLAG_BIT,
		OPND_INPUT_BIT,
		OPND_OUTPUT_BIT,
		OPND_TIMER,
		OPND_COUNTER,
		OPND_ORG_BLOCK,
		OPND_SEQ_BLOCK,
		OPND_FUNC_BLOCK,
		OPND_PROG_BLOCK,
		OPND_DATA_BLOCK,
		OPND_CONST
	} opnd_t;

	// index word area: flag word memory or current data block
	typedef enum logic {
		AREA_FLAG,
		AREA_DATA
	} area_t;

endpackage

/* File: verilog/indexed_permit.sv */
// indexed_permit: says whether a statement may follow an indexed instruction
// assumes operation and operand come from a decoded statement
`timescale 1ns/1ps
module indexed_permit
	import indexed_pkg::*;
(
	input  wire indexed_pkg::op_t   op,
	input  wire indexed_pkg::opnd_t opnd,
	output logic                    permitted,
	output logic                    bit_operand
);

	// ************************************************************
	// operand classes
	// ************************************************************
	wire is_ldtr_opnd = (opnd == OPND_FLAG_BYTE) || (opnd == OPND_FLAG_WORD) ||
		(opnd == OPND_INPUT_BYTE) || (opnd == OPND_OUTPUT_BYTE) ||
		(opnd == OPND_INPUT_WORD) || (opnd == OPND_OUTPUT_WORD) ||
		(opnd == OPND_DATA_LEFT) || (opnd == OPND_DATA_RIGHT) ||
		(opnd == OPND_DATA_WORD);
	wire is_block = (opnd == OPND_ORG_BLOCK) || (opnd == OPND_SEQ_BLOCK) ||
		(opnd == OPND_FUNC_BLOCK) || (opnd == OPND_PROG_BLOCK);
	wire is_flag  = (opnd == OPND_FLAG_BIT);
	wire is_timer = (opnd == OPND_TIMER);

	// ************************************************************
	// permitted pairings
	// ************************************************************
	wire ok_ldtr  = ((op == OP_LOAD) || (op == OP_TRANSFER)) && is_ldtr_opnd;
	wire ok_cdb   = (op == OP_SELECT_DB);
	wire ok_call  = ((op == OP_JUMP_U) || (op == OP_JUMP_C)) && is_block;
	wire ok_bool  = ((op == OP_AND) && (is_flag || is_timer)) ||
		((op == OP_ASSIGN) && is_flag) || ((op == OP_AND_NOT) && is_timer);
	wire ok_sr    = ((op == OP_SET) && is_flag) ||
		((op == OP_RESET) && (is_flag || is_timer));
	wire ok_timer = ((op == OP_TIMER_SS) || (op == OP_TIMER_SE)) && is_timer;
	wire ok_shift = (op == OP_SHIFT_L) || (op == OP_SHIFT_R);

	// another indexed instruction is never a legal partner
	assign permitted   = ok_ldtr || ok_cdb || ok_call || ok_bool || ok_sr ||
		ok_timer || ok_shift;
	assign bit_operand = (opnd == OPND_FLAG_BIT) || (opnd == OPND_INPUT_BIT) ||
		(opnd == OPND_OUTPUT_BIT);

endmodule

/* File: bench/index_word_mem.sv */
// index_word_mem: flag and data word store answering index word reads
// assumes one read in flight; lat sets the answer delay in cycles
`timescale 1ns/1ps
module index_word_mem
	import indexed_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               mem_rd_req,
	input  wire indexed_pkg::area_t mem_rd_area,
	input  wire logic [7:0]         mem_rd_addr,
	input  wire logic [2:0]         lat,
	output logic                    mem_rd_valid,
	output logic [15:0]             mem_rd_data
);
	logic [15:0] words [2][256];
	logic [15:0] pend;
	int          cnt = -1;
	initial begin
		mem_rd_valid = 1'b0;
		mem_rd_data = 16'h0000;
	end
	// data toggles when idle so a stale word never passes for an answer
	always @(posedge clk) begin
		mem_rd_valid <= 1'b0;
		mem_rd_data <= ~mem_rd_data;
		if (mem_rd_req) begin
			pend = words[mem_rd_area][mem_rd_addr];
			cnt = lat;
		end else if (cnt > 0) begin
			cnt--;
		end
		if (cnt == 0) begin
			mem_rd_valid <= 1'b1;
			mem_rd_data <= pend;
			cnt = -1;
		end
	end
endmodule

/* File: bench/indexed_asserts.sv */
// checker: pairing and substitution timing of the indexed block
// assumes it is bound onto indexed_operand_substitution
`timescale 1ns/1ps
module indexed_asserts
	import indexed_pkg::*;
(
	input wire logic               clk,
	input wire logic               srst,
	input wire logic               stmt_valid,
	input wire logic               stmt_ready,
	input wire indexed_pkg::op_t   stmt_op,
	input wire logic [15:0]        stmt_param,
	input wire logic               mem_rd_req,
	input wire logic               exec_valid,
	input wire indexed_pkg::opnd_t exec_opnd,
	input wire logic [15:0]        exec_param,
	input wire logic               exec_indexed,
	input wire logic               pair_busy,
	input wire logic               index_error
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire take = stmt_valid && stmt_ready;
	wire do_t = take && stmt_op == OP_DO;
	wire bit_x = exec_opnd == OPND_FLAG_BIT;
	property p_start; do_t |=> mem_rd_req ^ index_error; endproperty
	a_start: assert property (p_start) else $error("do start");
	property p_range; do_t && stmt_param[7:0] > INDEX_MAX |=> index_error; endproperty
	a_range: assert property (p_range) else $error("index range");
	property p_hold; mem_rd_req |-> pair_busy && !stmt_ready; endproperty
	a_hold: assert property (p_hold) else $error("pair split");
	property p_end; $fell(pair_busy) |-> exec_valid || index_error; endproperty
	a_end: assert property (p_end) else $error("pair end");
	property p_word; exec_indexed && !bit_x |-> exec_param[15:8] == 8'h00; endproperty
	a_word: assert property (p_word) else $error("word subst");
	property p_pair; exec_indexed |-> exec_valid && !pair_busy && $past(pair_busy); endproperty
	a_pair: assert property (p_pair) else $error("pair scope");
	property p_plain;
		take && !pair_busy && stmt_op != OP_DO |=> exec_valid && !exec_indexed
			&& exec_param == $past(stmt_param);
	endproperty
	a_plain: assert property (p_plain) else $error("plain stmt");
	property p_bad; index_error |-> !exec_valid && !mem_rd_req; endproperty
	a_bad: assert property (p_bad) else $error("error pair");
	cover property (exec_indexed && bit_x);
	cover property (exec_indexed && !bit_x);
	cover property (index_error);
endmodule
bind indexed_operand_substitution indexed_asserts chk (
	.clk(clk), .srst(srst), .stmt_valid(stmt_valid), .stmt_ready(stmt_ready),
	.stmt_op(stmt_op), .stmt_param(stmt_param), .mem_rd_req(mem_rd_req),
	.exec_valid(exec_valid), .exec_opnd(exec_opnd), .exec_param(exec_param),
	.exec_indexed(exec_indexed), .pair_busy(pair_busy), .index_error(index_error)
);

/* File: bench/testbench.sv */
// testbench: statement driver and checks for indexed pairs
// assumes index_word_mem stands in for the word store
`timescale 1ns/1ps
module testbench;
	import indexed_pkg::*;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        stmt_valid = 1'b0;
	op_t         stmt_op = OP_OTHER;
	opnd_t       stmt_opnd = OPND_NONE;
	logic [15:0] stmt_param = 16'h0000;
	logic [2:0]  lat = 3'h0;
	logic        stmt_ready, mem_rd_req, mem_rd_valid, exec_valid, exec_indexed;
	logic        pair_busy, index_error;
	area_t       mem_rd_area;
	logic [7:0]  mem_rd_addr;
	logic [15:0] mem_rd_data, exec_param;
	op_t         exec_op;
	opnd_t       exec_opnd;
	int          num_errors = 0;
	int          samples_checked = 0;
	initial begin
		forever #4 clk = ~clk;
	end
	indexed_operand_substitution dut (
		.clk(clk), .srst(srst), .stmt_valid(stmt_valid), .stmt_op(stmt_op),
		.stmt_opnd(stmt_opnd), .stmt_param(stmt_param), .stmt_ready(stmt_ready),
		.mem_rd_req(mem_rd_req), .mem_rd_area(mem_rd_area), .mem_rd_addr(mem_rd_addr),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .exec_valid(exec_valid),
		.exec_op(exec_op), .exec_opnd(exec_opnd), .exec_param(exec_param),
		.exec_indexed(exec_indexed), .pair_busy(pair_busy), .index_error(index_error)
	);
	index_word_mem mem (
		.clk(clk), .mem_rd_req(mem_rd_req), .mem_rd_area(mem_rd_area),
		.mem_rd_addr(mem_rd_addr), .lat(lat), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data)
	);
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// holds the statement until taken; outputs judged in the cycle after
	task automatic put(input op_t op, input opnd_t od, input logic [15:0] prm);
		int n;
		n = 0;
		stmt_valid = 1'b1;
		stmt_op = op;
		stmt_opnd = od;
		stmt_param = prm;
		do begin
			@(posedge clk);
			n++;
		end while (stmt_ready !== 1'b1 && n < 40);
		if (stmt_ready !== 1'b1) begin
			num_errors++;
			complete_run();
		end
		@(negedge clk);
	endtask
	task automatic idx(input area_t a, input logic [7:0] i, input logic [15:0] w);
		mem.words[a][i] = w;
		put(OP_DO, a == AREA_DATA ? OPND_DATA_WORD : OPND_FLAG_WORD, {8'h00, i});
		chk("rd_req", mem_rd_req, 1'b1);
		chk("rd_addr", {mem_rd_area, 7'h00, mem_rd_addr}, {a, 7'h00, i});
		chk("busy", pair_busy, 1'b1);
	endtask
	task automatic s_plain();
		chk("op_rst", exec_op, OP_OTHER);
		put(OP_LOAD, OPND_FLAG_WORD, 16'h0033);
		chk("param", exec_param, 16'h0033);
		put(OP_SET, OPND_FLAG_BIT, 16'h0502);
		chk("valid", exec_valid, 1'b1);
		chk("indexed", exec_indexed, 1'b0);
	endtask
	task automatic s_pairs();
		op_t ops[14] = '{OP_LOAD, OP_TRANSFER, OP_SELECT_DB, OP_JUMP_U, OP_JUMP_C, OP_AND,
			OP_ASSIGN, OP_AND_NOT, OP_SET, OP_RESET, OP_TIMER_SS, OP_TIMER_SE, OP_SHIFT_L,
			OP_SHIFT_R};
		opnd_t ods[14] = '{OPND_DATA_WORD, OPND_FLAG_BYTE, OPND_DATA_BLOCK, OPND_FUNC_BLOCK,
			OPND_PROG_BLOCK, OPND_FLAG_BIT, OPND_FLAG_BIT, OPND_TIMER, OPND_FLAG_BIT,
			OPND_TIMER, OPND_TIMER, OPND_TIMER, OPND_CONST, OPND_CONST};
		logic [15:0] w;
		for (int i = 0; i < 14; i++) begin
			w = ods[i] == OPND_FLAG_BIT ? {8'h05, i[7:0]} : {8'h00, 8'h20 + i[7:0]};
			lat = i[2:0];
			idx(area_t'(i[0]), i == 0 ? 8'hfe : 8'h0c, w);
			put(ops[i], ods[i], 16'h0000);
			chk("indexed", exec_indexed, 1'b1);
			chk("param", exec_param, w);
			chk("busy", pair_busy, 1'b0);
			chk("op", exec_op, ops[i]);
			chk("opnd", exec_opnd, ods[i]);
			put(ops[i], ods[i], 16'h0007);
			chk("param", exec_param, 16'h0007);
		end
	endtask
	task automatic s_bad();
		op_t bad[3] = '{OP_OR, OP_INCREMENT, OP_DO};
		put(OP_DO, OPND_DATA_WORD, 16'h00ff);
		chk("err", index_error, 1'b1);
		chk("rd_req", mem_rd_req, 1'b0);
		put(OP_DO, OPND_FLAG_BYTE, 16'h0003);
		chk("err", index_error, 1'b1);
		for (int i = 0; i < 3; i++) begin
			idx(AREA_DATA, 8'h02, 16'h0004);
			put(bad[i], OPND_FLAG_WORD, 16'h0000);
			chk("err", index_error, 1'b1);
			chk("valid", exec_valid, 1'b0);
		end
		idx(AREA_FLAG, 8'h03, 16'h0004);
		put(OP_AND, OPND_INPUT_BIT, 16'h0000);
		chk("err", index_error, 1'b1);
		put(OP_LOAD, OPND_DATA_WORD, 16'h0009);
		chk("indexed", exec_indexed, 1'b0);
		stmt_valid = 1'b0;
	endtask
	// reset lands while the word read of a pair is still pending
	task automatic s_reset();
		idx(AREA_DATA, 8'h05, 16'h0011);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		chk("rst_busy", pair_busy, 1'b0);
		chk("rst_ready", stmt_ready, 1'b0);
		srst = 1'b0;
		put(OP_LOAD, OPND_DATA_WORD, 16'h0044);
		chk("rst_param", exec_param, 16'h0044);
		chk("rst_indexed", exec_indexed, 1'b0);
		stmt_valid = 1'b0;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		s_plain();
		s_pairs();
		s_bad();
		s_reset();
		repeat (3) @(negedge clk);
		complete_run();
	end
endmodule
